// *** hdl/add_unit_defs.svh ***
`ifndef ADD_UNIT_DEFS_SVH
`define ADD_UNIT_DEFS_SVH

// ------------------------------------------------------------
// instruction word field positions (bit 31 = leading bit 0)
// ------------------------------------------------------------
`define AU_IMM_HI        15
`define AU_IMM_LO        0
`define AU_IMM_SIGN      15
`define AU_HALF_WIDTH    16

// ------------------------------------------------------------
// primary and extended opcode values
// ------------------------------------------------------------
`define AU_OP_EXT        6'h1f
`define AU_OP_ADDIC      6'h0c
`define AU_OP_ADDIC_REC  6'h0d
`define AU_OP_ADDI       6'h0e
`define AU_OP_ADDIS      6'h0f
`define AU_XO_ADD        9'h10a
`define AU_XO_ADDC       9'h00a
`define AU_XO_ADDE       9'h08a
`define AU_SEL_ZERO      5'h00

// ------------------------------------------------------------
// register offsets, byte addresses on the avalon slave
// ------------------------------------------------------------
`define AU_REG_FLAGS     4'h0
`define AU_REG_COND      4'h4
`define AU_REG_EXEC_CNT  4'h8
`define AU_REG_ILL_CNT   4'hc
`define AU_FLAGS_HI      2
`define AU_COND_HI       3
`define AU_BE_LOW        0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define AU_FLAGS_RST     3'h0
`define AU_COND_RST      4'h0
`define AU_SEL_RST       5'h00

`endif

// *** hdl/add_unit_pkg.sv ***
package add_unit_pkg;

   // -----------------------------------------------------------
   // decoded instruction word, leading bit first
   // -----------------------------------------------------------
   typedef struct packed {
      logic [5:0] opcode;
      logic [4:0] dest_gpr_sel;
      logic [4:0] src_a_gpr_sel;
      logic [4:0] src_b_gpr_sel;
      logic       oe_bit;
      logic [8:0] ext_opcode;
      logic       record_bit;
   } instr_fields_t;

   // -----------------------------------------------------------
   // exception register flags and condition field
   // -----------------------------------------------------------
   typedef struct packed {
      logic summary_ovf;
      logic overflow_flag;
      logic carry_flag;
   } fx_flags_t;

   typedef struct packed {
      logic result_negative_bit;
      logic result_positive_bit;
      logic result_zero_bit;
      logic summary_ovf;
   } cond_field_t;

   // -----------------------------------------------------------
   // operation kinds
   // -----------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NONE      = 3'h0,
      OP_ADD       = 3'h1,
      OP_ADDC      = 3'h3,
      OP_ADDE      = 3'h2,
      OP_ADDI      = 3'h6,
      OP_ADDIC     = 3'h7,
      OP_ADDIC_REC = 3'h5,
      OP_ADDIS     = 3'h4
   } op_kind_t;

   typedef struct packed {
      op_kind_t kind;
      logic     wr_carry;
      logic     wr_ovf;
      logic     wr_cond;
   } exec_ctl_t;

endpackage

// *** hdl/add_core.sv ***
`timescale 1ns/1ns
`default_nettype none

module add_core #(
   parameter int WIDTH = 32
) (
   // operands
   input  wire logic [WIDTH-1:0] i_a,
   input  wire logic [WIDTH-1:0] i_b,
   input  wire logic             i_cin,
   // results
   output logic      [WIDTH-1:0] o_sum,
   output logic                  o_cout,
   output logic                  o_ovf
);

   // -----------------------------------------------------------
   // full-width sum with carry out
   // -----------------------------------------------------------
   assign {o_cout, o_sum} = {1'b0, i_a} + {1'b0, i_b}
                          + {{WIDTH{1'b0}}, i_cin};

   // signed overflow: like signs in, other sign out
   assign o_ovf = (i_a[WIDTH-1] == i_b[WIDTH-1])
                & (o_sum[WIDTH-1] != i_a[WIDTH-1]);

endmodule // add_core

`default_nettype wire

// *** hdl/integer_add_family_unit.sv ***

`timescale 1ns/1ns
`default_nettype none

`include "add_unit_defs.svh"

module integer_add_family_unit #(
   parameter int DATA_W = 32,
   parameter int CNT_W  = 32
) (
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // instruction issue from decoder and register file
   input  wire logic              i_issue_valid,
   input  wire logic [31:0]       i_instr,
   input  wire logic [DATA_W-1:0] i_src_a_val,
   input  wire logic [DATA_W-1:0] i_src_b_val,
   // destination register write
   output logic                   o_wb_valid,
   output logic      [4:0]        o_wb_dest_gpr_sel,
   output logic      [DATA_W-1:0] o_wb_data,
   output logic                   o_illegal_instr,
   // architected flags
   output logic                   o_carry_flag,
   output logic                   o_overflow_flag,
   output logic                   o_summary_ovf,
   output logic      [3:0]        o_cond_field_zero,
   // avalon-mm slave
   input  wire logic [3:0]        i_avs_address,
   input  wire logic              i_avs_read,
   input  wire logic              i_avs_write,
   input  wire logic [31:0]       i_avs_writedata,
   input  wire logic [3:0]        i_avs_byteenable,
   output logic      [31:0]       o_avs_readdata,
   output logic                   o_avs_waitrequest
);

   // -----------------------------------------------------------
   // declarations
   // -----------------------------------------------------------
   add_unit_pkg::instr_fields_t fields;
   add_unit_pkg::exec_ctl_t     ctl;
   add_unit_pkg::fx_flags_t     flags_reg;
   add_unit_pkg::fx_flags_t     flags_next;
   add_unit_pkg::cond_field_t   cond_reg;
   add_unit_pkg::cond_field_t   cond_next;
   add_unit_pkg::cond_field_t   cond_calc;

   logic [15:0]       imm;
   logic [DATA_W-1:0] imm_sext;
   logic [DATA_W-1:0] imm_shift;
   logic [DATA_W-1:0] ra_or_zero;
   logic [DATA_W-1:0] op_a;
   logic [DATA_W-1:0] op_b;
   logic              op_cin;
   logic [DATA_W-1:0] sum;
   logic              carry_out;
   logic              ovf;
   logic              exec;
   logic              illegal;

   logic              wb_valid_reg;
   logic [4:0]        wb_sel_reg;
   logic [DATA_W-1:0] wb_data_reg;
   logic              illegal_reg;
   logic [CNT_W-1:0]  exec_cnt_reg;
   logic [CNT_W-1:0]  ill_cnt_reg;

   logic              wait_reg;
   logic              wait_next;
   logic [31:0]       rdata_reg;
   logic [31:0]       rdata_next;
   logic              bus_req;
   logic              bus_done;
   logic              wr_flags;
   logic              wr_cond;

   // -----------------------------------------------------------
   // field extraction
   // -----------------------------------------------------------
   assign fields = add_unit_pkg::instr_fields_t'(i_instr);
   assign imm    = i_instr[`AU_IMM_HI:`AU_IMM_LO];

   assign imm_sext  = {{(DATA_W-`AU_HALF_WIDTH){imm[`AU_IMM_SIGN]}},
                       imm};
   assign imm_shift = {imm[DATA_W-`AU_HALF_WIDTH-1:0],
                       {`AU_HALF_WIDTH{1'b0}}};
   assign ra_or_zero = (fields.src_a_gpr_sel == `AU_SEL_ZERO)
                     ? '0 : i_src_a_val;

   // -----------------------------------------------------------
   // decode and operand selection
   // -----------------------------------------------------------
   always_comb
   begin
      ctl.kind = add_unit_pkg::OP_NONE;
      op_a     = i_src_a_val;
      op_b     = i_src_b_val;
      op_cin   = 1'b0;
      case (fields.opcode)
         `AU_OP_EXT:
         begin
            case (fields.ext_opcode)
               `AU_XO_ADD:  ctl.kind = add_unit_pkg::OP_ADD;
               `AU_XO_ADDC: ctl.kind = add_unit_pkg::OP_ADDC;
               `AU_XO_ADDE:
               begin
                  ctl.kind = add_unit_pkg::OP_ADDE;
                  op_cin   = flags_reg.carry_flag;
               end
               default:     ctl.kind = add_unit_pkg::OP_NONE;
            endcase
         end
         `AU_OP_ADDIC:
         begin
            ctl.kind = add_unit_pkg::OP_ADDIC;
            op_b     = imm_sext;
         end
         `AU_OP_ADDIC_REC:
         begin
            ctl.kind = add_unit_pkg::OP_ADDIC_REC;
            op_b     = imm_sext;
         end
         `AU_OP_ADDI:
         begin
            ctl.kind = add_unit_pkg::OP_ADDI;
            op_a     = ra_or_zero;
            op_b     = imm_sext;
         end
         `AU_OP_ADDIS:
         begin
            ctl.kind = add_unit_pkg::OP_ADDIS;
            op_a     = ra_or_zero;
            op_b     = imm_shift;
         end
         default:    ctl.kind = add_unit_pkg::OP_NONE;
      endcase
      // side-effect controls follow from the decoded kind
      ctl.wr_carry = 1'b0;
      ctl.wr_ovf   = 1'b0;
      ctl.wr_cond  = 1'b0;
      unique case (ctl.kind)
         add_unit_pkg::OP_ADD:
         begin
            ctl.wr_ovf  = fields.oe_bit;
            ctl.wr_cond = fields.record_bit;
         end
         add_unit_pkg::OP_ADDC,
         add_unit_pkg::OP_ADDE:
         begin
            ctl.wr_carry = 1'b1;
            ctl.wr_ovf   = fields.oe_bit;
            ctl.wr_cond  = fields.record_bit;
         end
         add_unit_pkg::OP_ADDIC:
            ctl.wr_carry = 1'b1;
         add_unit_pkg::OP_ADDIC_REC:
         begin
            ctl.wr_carry = 1'b1;
            ctl.wr_cond  = 1'b1;
         end
         add_unit_pkg::OP_NONE,
         add_unit_pkg::OP_ADDI,
         add_unit_pkg::OP_ADDIS:
            ctl.wr_carry = 1'b0;
      endcase
   end

   assign exec    = i_issue_valid & (ctl.kind != add_unit_pkg::OP_NONE);
   assign illegal = i_issue_valid & (ctl.kind == add_unit_pkg::OP_NONE);

   // -----------------------------------------------------------
   // adder
   // -----------------------------------------------------------
   add_core #(
      .WIDTH  (DATA_W)
   ) u_add_core (
      .i_a    (op_a),
      .i_b    (op_b),
      .i_cin  (op_cin),
      .o_sum  (sum),
      .o_cout (carry_out),
      .o_ovf  (ovf)
   );

   // -----------------------------------------------------------
   // destination write
   // -----------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         wb_valid_reg <= 1'b0;
         wb_sel_reg   <= `AU_SEL_RST;
         wb_data_reg  <= '0;
      end
      else
      begin
         wb_valid_reg <= exec;
         if (exec)
         begin
            wb_sel_reg  <= fields.dest_gpr_sel;
            wb_data_reg <= sum;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         illegal_reg <= 1'b0;
      else
         illegal_reg <= illegal;
   end

   // -----------------------------------------------------------
   // exception flags: instruction wins over a bus write
   // -----------------------------------------------------------
   assign wr_flags = bus_done & i_avs_write
                   & (i_avs_address == `AU_REG_FLAGS)
                   & i_avs_byteenable[`AU_BE_LOW];
   assign wr_cond  = bus_done & i_avs_write
                   & (i_avs_address == `AU_REG_COND)
                   & i_avs_byteenable[`AU_BE_LOW];

   always_comb
   begin
      flags_next = flags_reg;
      if (wr_flags)
         flags_next = add_unit_pkg::fx_flags_t'(
                         i_avs_writedata[`AU_FLAGS_HI:0]);
      if (exec & ctl.wr_carry)
         flags_next.carry_flag = carry_out;
      if (exec & ctl.wr_ovf)
      begin
         flags_next.overflow_flag = ovf;
         flags_next.summary_ovf   = flags_next.summary_ovf | ovf;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         flags_reg <= add_unit_pkg::fx_flags_t'(`AU_FLAGS_RST);
      else
         flags_reg <= flags_next;
   end

   // -----------------------------------------------------------
   // condition field zero
   // -----------------------------------------------------------
   always_comb
   begin
      cond_calc.result_negative_bit = sum[DATA_W-1];
      cond_calc.result_positive_bit = ~sum[DATA_W-1]
                                    & (sum != '0);
      cond_calc.result_zero_bit     = (sum == '0);
      cond_calc.summary_ovf         = flags_next.summary_ovf;
   end

   always_comb
   begin
      cond_next = cond_reg;
      if (wr_cond)
         cond_next = add_unit_pkg::cond_field_t'(
                        i_avs_writedata[`AU_COND_HI:0]);
      if (exec & ctl.wr_cond)
         cond_next = cond_calc;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         cond_reg <= add_unit_pkg::cond_field_t'(`AU_COND_RST);
      else
         cond_reg <= cond_next;
   end

   // -----------------------------------------------------------
   // activity counters
   // -----------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         exec_cnt_reg <= '0;
      else if (exec)
         exec_cnt_reg <= exec_cnt_reg + 1'b1;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         ill_cnt_reg <= '0;
      else if (illegal)
         ill_cnt_reg <= ill_cnt_reg + 1'b1;
   end

   // -----------------------------------------------------------
   // avalon-mm slave: one wait cycle, then a one-cycle answer
   // -----------------------------------------------------------
   assign bus_req   = i_avs_read | i_avs_write;
   assign bus_done  = bus_req & ~wait_reg;
   assign wait_next = ~(bus_req & wait_reg);

   always_comb
   begin
      rdata_next = 32'h0000_0000;
      case (i_avs_address)
         `AU_REG_FLAGS:    rdata_next = 32'(flags_reg);
         `AU_REG_COND:     rdata_next = 32'(cond_reg);
         `AU_REG_EXEC_CNT: rdata_next = 32'(exec_cnt_reg);
         `AU_REG_ILL_CNT:  rdata_next = 32'(ill_cnt_reg);
         default:          rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         wait_reg <= 1'b1;
      else
         wait_reg <= wait_next;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         rdata_reg <= 32'h0000_0000;
      else if (i_avs_read & wait_reg)
         rdata_reg <= rdata_next;
   end

   // -----------------------------------------------------------
   // outputs
   // -----------------------------------------------------------
   assign o_wb_valid        = wb_valid_reg;
   assign o_wb_dest_gpr_sel = wb_sel_reg;
   assign o_wb_data         = wb_data_reg;
   assign o_illegal_instr   = illegal_reg;
   assign o_carry_flag      = flags_reg.carry_flag;
   assign o_overflow_flag   = flags_reg.overflow_flag;
   assign o_summary_ovf     = flags_reg.summary_ovf;
   assign o_cond_field_zero = cond_reg;
   assign o_avs_readdata    = rdata_reg;
   assign o_avs_waitrequest = wait_reg;

endmodule // integer_add_family_unit

`default_nettype wire

// *** tb/integer_add_family_unit_checker.sv ***
`timescale 1ns/1ns
`default_nettype none

module integer_add_family_unit_checker (
   // clock and reset
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   // issue and bus
   input wire logic        i_issue_valid,
   input wire logic [31:0] i_instr,
   input wire logic [31:0] i_src_a_val,
   input wire logic [31:0] i_src_b_val,
   input wire logic        i_avs_write,
   input wire logic        o_avs_waitrequest,
   // results
   input wire logic        o_wb_valid,
   input wire logic        o_illegal_instr,
   input wire logic [4:0]  o_wb_dest_gpr_sel,
   input wire logic [31:0] o_wb_data,
   input wire logic        o_carry_flag,
   input wire logic        o_overflow_flag,
   input wire logic        o_summary_ovf,
   input wire logic [3:0]  o_cond_field_zero
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   // ------
   // helper values
   // ------
   wire logic [32:0] sum_ab  = {1'b0, i_src_a_val} + {1'b0, i_src_b_val};
   wire logic [32:0] sum_abc = sum_ab + {32'h0, o_carry_flag};
   wire logic [31:0] sum32   = sum_ab[31:0];
   wire logic [4:0]  dest    = i_instr[25:21];
   wire logic [8:0]  xo      = i_instr[9:1];
   wire logic [31:0] imm_sx  = {{16{i_instr[15]}}, i_instr[15:0]};
   wire logic        bus_wr  = i_avs_write && !o_avs_waitrequest;
   wire logic        ovf_ab  = (i_src_a_val[31] == i_src_b_val[31])
                               && (sum32[31] != i_src_a_val[31]);

   sequence s_reg;
      i_issue_valid && i_instr[31:26] == 6'h1f;
   endsequence

   a_issue_answer: assert property (i_issue_valid |=>
      o_wb_valid ^ o_illegal_instr)
      else $error("issue gave no single answer");
   a_add_sum: assert property (s_reg and xo == 9'h10a |=>
      o_wb_valid && o_wb_data == $past(sum32)
      && o_wb_dest_gpr_sel == $past(dest))
      else $error("add result wrong");
   a_addc_carry: assert property (s_reg and xo == 9'h00a |=>
      {o_carry_flag, o_wb_data} == $past(sum_ab))
      else $error("carrying sum wrong");
   a_adde_sum: assert property (s_reg and xo == 9'h08a |=>
      {o_carry_flag, o_wb_data} == $past(sum_abc))
      else $error("extended sum wrong");
   a_ovf_hold: assert property (s_reg and !i_instr[10] && !bus_wr |=>
      $stable(o_overflow_flag) && $stable(o_summary_ovf))
      else $error("overflow flags moved");
   a_cond_hold: assert property (s_reg and !i_instr[0] && !bus_wr |=>
      $stable(o_cond_field_zero))
      else $error("condition field moved");
   a_ovf_sets: assert property (s_reg and i_instr[10] && xo == 9'h10a
      && ovf_ab |=> o_overflow_flag && o_summary_ovf)
      else $error("overflow not recorded");
   a_addi_zero: assert property (i_issue_valid
      && i_instr[31:26] == 6'h0e
      && i_instr[20:16] == 5'h00 |=> o_wb_data == $past(imm_sx))
      else $error("immediate load wrong");
   a_rec_cond: assert property (i_issue_valid
      && i_instr[31:26] == 6'h0d |=>
      o_cond_field_zero == {$signed(o_wb_data) < 0, $signed(o_wb_data) > 0,
      o_wb_data == 32'h0, o_summary_ovf})
      else $error("recorded condition wrong");
endmodule // integer_add_family_unit_checker

bind integer_add_family_unit integer_add_family_unit_checker chk_i (
   .i_clk, .i_rst_n, .i_issue_valid, .i_instr, .i_src_a_val, .i_src_b_val,
   .i_avs_write, .o_avs_waitrequest, .o_wb_valid, .o_illegal_instr,
   .o_wb_dest_gpr_sel, .o_wb_data, .o_carry_flag, .o_overflow_flag,
   .o_summary_ovf, .o_cond_field_zero
);

`default_nettype wire

// *** tb/gpr_file_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module gpr_file_model (
   // clock
   input  wire logic        i_clk,
   // preload from bench
   input  wire logic        i_load_en,
   input  wire logic [4:0]  i_load_sel,
   input  wire logic [31:0] i_load_val,
   // operand read
   input  wire logic [31:0] i_instr,
   output logic      [31:0] o_src_a_val,
   output logic      [31:0] o_src_b_val,
   // destination write
   input  wire logic        i_wb_valid,
   input  wire logic [4:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_data
);
   logic [31:0] gpr_reg [32];

   always_ff @(posedge i_clk)
   begin
      if (i_load_en)
         gpr_reg[i_load_sel] <= i_load_val;
      else if (i_wb_valid)
         gpr_reg[i_wb_sel] <= i_wb_data;
   end

   assign o_src_a_val = gpr_reg[i_instr[20:16]];
   assign o_src_b_val = gpr_reg[i_instr[15:11]];
endmodule // gpr_file_model

`default_nettype wire

// *** tb/tb_integer_add_family_unit.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb_integer_add_family_unit;
   logic        i_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        i_issue_valid = 1'b0;
   logic [31:0] i_instr = 32'h0;
   logic [3:0]  i_avs_address = 4'h0;
   logic        i_avs_read = 1'b0;
   logic        i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [3:0]  i_avs_byteenable = 4'h0;
   logic        load_en = 1'b0;
   logic [4:0]  load_sel = 5'h0;
   logic [31:0] load_val = 32'h0;
   logic [31:0] rd;
   logic [31:0] init [4] = '{32'h12345678, 32'hffffffff, 32'h1, 32'h7fffffff};
   wire logic [31:0] i_src_a_val;
   wire logic [31:0] i_src_b_val;
   wire logic        o_wb_valid;
   wire logic [4:0]  o_wb_dest_gpr_sel;
   wire logic [31:0] o_wb_data;
   wire logic        o_illegal_instr;
   wire logic        o_carry_flag;
   wire logic        o_overflow_flag;
   wire logic        o_summary_ovf;
   wire logic [3:0]  o_cond_field_zero;
   wire logic [31:0] o_avs_readdata;
   wire logic        o_avs_waitrequest;
   int bad_count = 0;
   int checked = 0;

   always #25 i_clk = ~i_clk;

   integer_add_family_unit integer_add_family_unit_i (.i_clk(i_clk),
      .i_rst_n(i_rst_n), .i_issue_valid(i_issue_valid), .i_instr(i_instr),
      .i_src_a_val(i_src_a_val), .i_src_b_val(i_src_b_val),
      .o_wb_valid(o_wb_valid), .o_wb_dest_gpr_sel(o_wb_dest_gpr_sel),
      .o_wb_data(o_wb_data), .o_illegal_instr(o_illegal_instr),
      .o_carry_flag(o_carry_flag), .o_overflow_flag(o_overflow_flag),
      .o_summary_ovf(o_summary_ovf), .o_cond_field_zero(o_cond_field_zero),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest));

   gpr_file_model gpr_file_model_i (.i_clk(i_clk), .i_load_en(load_en),
      .i_load_sel(load_sel), .i_load_val(load_val), .i_instr(i_instr),
      .o_src_a_val(i_src_a_val), .o_src_b_val(i_src_b_val),
      .i_wb_valid(o_wb_valid), .i_wb_sel(o_wb_dest_gpr_sel),
      .i_wb_data(o_wb_data));

   // ------
   // helpers
   // ------
   function automatic logic [31:0] xf(input logic [4:0] d, a, b,
      input logic oe, input logic [8:0] xo, input logic rc);
      return {6'h1f, d, a, b, oe, xo, rc};
   endfunction

   function automatic logic [31:0] df(input logic [5:0] op,
      input logic [4:0] d, a, input logic [15:0] imm);
      return {op, d, a, imm};
   endfunction

   task automatic test_done();
      if (bad_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic run(input logic [31:0] ins, input logic ill);
      @(posedge i_clk);
      i_issue_valid <= 1'b1;
      i_instr <= ins;
      @(posedge i_clk);
      i_issue_valid <= 1'b0;
      #1;
      chk(o_illegal_instr, ill);
      chk(o_wb_valid, !ill);
   endtask

   task automatic res(input logic [31:0] d, input logic [2:0] f,
      input logic [3:0] c);
      chk(o_wb_data, d);
      chk({o_summary_ovf, o_overflow_flag, o_carry_flag}, f);
      chk(o_cond_field_zero, c);
   endtask

   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] wd, input logic [3:0] be);
      int n;
      @(posedge i_clk);
      i_avs_read <= !wr;
      i_avs_write <= wr;
      i_avs_address <= a;
      i_avs_writedata <= wd;
      i_avs_byteenable <= be;
      for (n = 0; n < 20; n++)
      begin
         @(posedge i_clk);
         if (o_avs_waitrequest === 1'b0)
            break;
      end
      rd = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      if (n == 20)
      begin
         bad_count++;
         $display("[FAIL] %0t bus wait timed out", $time);
         test_done();
      end
   endtask

   // ------
   // main sequence
   // ------
   initial
   begin
      for (int r = 0; r < 4; r++)
      begin
         @(posedge i_clk);
         load_en <= 1'b1;
         load_sel <= r[4:0];
         load_val <= init[r];
      end
      @(posedge i_clk);
      load_en <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      chk({o_summary_ovf, o_overflow_flag, o_carry_flag}, 3'h0);
      chk({o_avs_waitrequest, o_cond_field_zero}, 5'h10);
      run(xf(5'h04, 5'h01, 5'h02, 1'b1, 9'h10a, 1'b1), 1'b0);
      res(32'h0, 3'h0, 4'h2);
      chk(o_wb_dest_gpr_sel, 5'h04);
      @(posedge i_clk);
      i_issue_valid <= 1'b1;
      i_instr <= xf(5'h05, 5'h01, 5'h02, 1'b0, 9'h00a, 1'b0);
      @(posedge i_clk);
      i_instr <= xf(5'h06, 5'h02, 5'h02, 1'b0, 9'h08a, 1'b0);
      #1 res(32'h0, 3'h1, 4'h2);
      @(posedge i_clk);
      i_issue_valid <= 1'b0;
      #1 res(32'h3, 3'h0, 4'h2);
      run(xf(5'h07, 5'h03, 5'h02, 1'b1, 9'h10a, 1'b1), 1'b0);
      res(32'h80000000, 3'h6, 4'h9);
      run(xf(5'h08, 5'h02, 5'h02, 1'b0, 9'h10a, 1'b0), 1'b0);
      res(32'h2, 3'h6, 4'h9);
      run(xf(5'h08, 5'h02, 5'h02, 1'b1, 9'h10a, 1'b0), 1'b0);
      res(32'h2, 3'h4, 4'h9);
      run(df(6'h0e, 5'h09, 5'h00, 16'h8000), 1'b0);
      res(32'hffff8000, 3'h4, 4'h9);
      run(df(6'h0e, 5'h09, 5'h01, 16'h0002), 1'b0);
      res(32'h1, 3'h4, 4'h9);
      run(df(6'h0c, 5'h09, 5'h01, 16'h0001), 1'b0);
      res(32'h0, 3'h5, 4'h9);
      run(df(6'h0d, 5'h09, 5'h03, 16'h0000), 1'b0);
      res(32'h7fffffff, 3'h4, 4'h5);
      run(df(6'h0f, 5'h09, 5'h00, 16'h1234), 1'b0);
      res(32'h12340000, 3'h4, 4'h5);
      run(df(6'h0f, 5'h09, 5'h02, 16'hffff), 1'b0);
      res(32'hffff0001, 3'h4, 4'h5);
      run(xf(5'h09, 5'h01, 5'h02, 1'b1, 9'h1ff, 1'b1), 1'b1);
      res(32'hffff0001, 3'h4, 4'h5);
      run({6'h3f, 26'h0}, 1'b1);
      bus(1'b0, 4'h0, 32'h0, 4'hf);
      chk(rd, 32'h4);
      bus(1'b1, 4'h0, 32'h0, 4'hf);
      bus(1'b1, 4'h0, 32'h7, 4'h0);
      bus(1'b0, 4'h0, 32'h0, 4'hf);
      chk(rd, 32'h0);
      chk({o_summary_ovf, o_overflow_flag, o_carry_flag}, 3'h0);
      bus(1'b0, 4'h4, 32'h0, 4'hf);
      chk(rd, 32'h5);
      bus(1'b1, 4'h4, 32'ha, 4'h1);
      bus(1'b0, 4'h4, 32'h0, 4'hf);
      chk(rd, 32'ha);
      chk(o_cond_field_zero, 4'ha);
      bus(1'b0, 4'h8, 32'h0, 4'hf);
      chk(rd, 32'hc);
      bus(1'b1, 4'hc, 32'h0, 4'hf);
      bus(1'b0, 4'hc, 32'h0, 4'hf);
      chk(rd, 32'h2);
      bus(1'b0, 4'h2, 32'h0, 4'hf);
      chk(rd, 32'h0);
      test_done();
   end
endmodule // tb_integer_add_family_unit

`default_nettype wire
